// File: core/tfp_pkg.sv
/*
  tfp_pkg: constants for the 16-bit timer pwm waveform block.
  assumes: one clock domain, register port with one-cycle read latency.
*/
package tfp_pkg;
  // ---------------------------------------------------------------
  // register offsets (word index on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL     = 4'h0; // mode, output modes, dir
  localparam logic [3:0] REG_CMP_A    = 4'h1; // compare a buffer
  localparam logic [3:0] REG_CMP_B    = 4'h2; // compare b buffer
  localparam logic [3:0] REG_CAPTOP   = 4'h3; // capture top register
  localparam logic [3:0] REG_COUNT    = 4'h4; // count value
  localparam logic [3:0] REG_FLAGS    = 4'h5; // flags, write one to clear
  localparam logic [3:0] REG_ACT_A    = 4'h6; // active compare a
  localparam logic [3:0] REG_ACT_B    = 4'h7; // active compare b
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_WGM_LSB = 0;  // waveform_mode_select [3:0]
  localparam int CTRL_COMA_LSB = 4; // channel_a_output_mode [5:4]
  localparam int CTRL_COMB_LSB = 6; // channel b output mode [7:6]
  localparam int CTRL_DIRA = 8;     // pin_direction_bit a
  localparam int CTRL_DIRB = 9;     // pin_direction_bit b
  // flag register fields
  localparam int FLG_OVF  = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAP  = 3;
  // ---------------------------------------------------------------
  // waveform modes handled here
  // ---------------------------------------------------------------
  localparam logic [3:0] WGM_PC8   = 4'h1;
  localparam logic [3:0] WGM_PC9   = 4'h2;
  localparam logic [3:0] WGM_PC10  = 4'h3;
  localparam logic [3:0] WGM_F8    = 4'h5;
  localparam logic [3:0] WGM_F9    = 4'h6;
  localparam logic [3:0] WGM_F10   = 4'h7;
  localparam logic [3:0] WGM_PCCAP = 4'ha;
  localparam logic [3:0] WGM_PCA   = 4'hb;
  localparam logic [3:0] WGM_FCAP  = 4'he;
  localparam logic [3:0] WGM_FA    = 4'hf;
  // output modes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV    = 2'h3;
  // fixed tops
  localparam logic [15:0] TOP_8BIT  = 16'h00ff;
  localparam logic [15:0] TOP_9BIT  = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] BOTTOM    = 16'h0000;
  localparam logic [15:0] MAXVAL    = 16'hffff;
  localparam logic [15:0] ONE       = 16'h0001;
  localparam logic [9:0]  CTRL_RST  = 10'h000;
endpackage

// File: core/tfp_pwm.sv
/*
  tfp_pwm: fast and phase correct pwm waveform generation of a
  16-bit timer with two compare channels and a capture top register.
  assumes: a prescaler outside supplies tick, one clk cycle wide;
  software keeps register tops >= 3 and >= all compare values.
*/
// Added by the designer: the register addresses and the plain strobed port.
// Summary of operation
// - fast pwm: mode 2 clear on match, 3 inverse
// - pin driven only when direction bit says output
// - fast period is N times top plus one
// - fast compare zero gives one narrow spike
// - fast compare equal top gives constant level
// - fast mode 15 output mode 1 toggles pin a
// - fast pwm compare values are double buffered
// - modes 1,2,3,10,11 count up then down
// - phase correct: clear up, set down; 3 inverts
// - phase correct tops fixed, capture or compare a
// - counter holds top one tick before reversing
// - compare match sets that channel's flag
// - phase correct sets overflow at bottom
// - phase correct loads buffers and top flag at top
// - fixed top masks compare writes above resolution
// - top change: down old top, up new top
// - phase correct period is 2 N top
// - phase correct extremes give constant levels
// - phase correct mode 11 output mode 1 toggles a
// - fast tops fixed, capture or compare a
// - fast sets overflow and loads buffers at top
`timescale 1ns/1ns
module tfp_pwm
  import tfp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        tick,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             channel_a_output_pin,
  output logic             channel_b_output_pin,
  output logic             pin_a_oe,
  output logic             pin_b_oe,
  output logic      [3:0]  flags
);
  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    TFP_UP   = 2'b01,
    TFP_DOWN = 2'b10
  } tfp_dir_t;

  typedef struct packed {
    logic [9:0]  ctrl;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] act_a;
    logic [15:0] act_b;
    logic [15:0] cap_top;
    logic [15:0] count_value;
    tfp_dir_t    dir;
    logic        wave_a;
    logic        wave_b;
    logic [3:0]  flag;
    logic [15:0] rdata;
  } tfp_state_t;

  tfp_state_t r;
  tfp_state_t next_r;

  logic [3:0]  waveform_mode_select;
  logic [1:0]  channel_a_output_mode;
  logic [1:0]  channel_b_output_mode;
  logic        fast_mode;
  logic        pc_mode;
  logic        fixed_top;
  logic [15:0] top;
  logic [15:0] res_mask;
  logic        at_top;
  logic        at_bottom;
  logic        match_a;
  logic        match_b;
  logic        top_a;
  logic        top_cap;
  logic        step;

  // -------------------------------------------------------------
  // mode decode and top selection
  // -------------------------------------------------------------
  assign waveform_mode_select  = r.ctrl[CTRL_WGM_LSB +: 4];
  assign channel_a_output_mode = r.ctrl[CTRL_COMA_LSB +: 2];
  assign channel_b_output_mode = r.ctrl[CTRL_COMB_LSB +: 2];
  assign step = clk_en & tick;

  always_comb begin
    fast_mode = 1'b0;
    pc_mode   = 1'b0;
    fixed_top = 1'b0;
    top_a     = 1'b0;
    top_cap   = 1'b0;
    top       = MAXVAL;
    unique case (waveform_mode_select)
      WGM_PC8:   begin pc_mode = 1'b1; fixed_top = 1'b1; top = TOP_8BIT; end
      WGM_PC9:   begin pc_mode = 1'b1; fixed_top = 1'b1; top = TOP_9BIT; end
      WGM_PC10:  begin pc_mode = 1'b1; fixed_top = 1'b1; top = TOP_10BIT; end
      WGM_PCCAP: begin pc_mode = 1'b1; top_cap = 1'b1; top = r.cap_top; end
      WGM_PCA:   begin pc_mode = 1'b1; top_a = 1'b1; top = r.act_a; end
      WGM_F8:    begin fast_mode = 1'b1; fixed_top = 1'b1; top = TOP_8BIT; end
      WGM_F9:    begin fast_mode = 1'b1; fixed_top = 1'b1; top = TOP_9BIT; end
      WGM_F10:   begin fast_mode = 1'b1; fixed_top = 1'b1; top = TOP_10BIT; end
      WGM_FCAP:  begin fast_mode = 1'b1; top_cap = 1'b1; top = r.cap_top; end
      WGM_FA:    begin fast_mode = 1'b1; top_a = 1'b1; top = r.act_a; end
      default:   ; // other modes: counter free-runs up, no waveform
    endcase
  end

  assign res_mask  = fixed_top ? top : MAXVAL;
  assign at_top    = (r.count_value == top);
  assign at_bottom = (r.count_value == BOTTOM);
  assign match_a   = (r.count_value == r.act_a);
  assign match_b   = (r.count_value == r.act_b);

  // -------------------------------------------------------------
  // per-channel output action
  // -------------------------------------------------------------
  function automatic logic tfp_wave(
    input logic       cur,
    input logic [1:0] com,
    input logic       match,
    input logic       is_a,
    input logic       fast,
    input logic       pc,
    input logic       wrap,
    input logic       down,
    input logic       top_is_a
  );
    logic v;
    v = cur;
    if (com == COM_TOGGLE) begin
      if (is_a && top_is_a && match) v = ~cur;
    end else if (com == COM_NONINV || com == COM_INV) begin
      if (fast) begin
        // set at wrap, clear on match; match wins
        if (wrap) v = 1'b1;
        if (match) v = 1'b0;
      end else if (pc && match) begin
        v = down;
      end
      if (com == COM_INV && (fast || pc) && (wrap || match))
        v = ~v;
    end
    return v;
  endfunction

  // -------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------
  always_comb begin
    logic wrap;
    logic down_next;
    logic [15:0] base_a;
    logic [15:0] base_b;
    wrap      = 1'b0;
    down_next = 1'b0;
    base_a    = 16'h0000;
    base_b    = 16'h0000;
    next_r    = r;
    next_r.rdata = 16'h0000;
    if (clk_en) begin
      // register port
      if (wr) begin
        unique case (addr)
          REG_CTRL:   next_r.ctrl = wdata[9:0];
          REG_CMP_A:  next_r.buf_a = wdata & res_mask;
          REG_CMP_B:  next_r.buf_b = wdata & res_mask;
          REG_CAPTOP: next_r.cap_top = wdata;
          REG_COUNT:  next_r.count_value = wdata;
          REG_FLAGS:  next_r.flag = r.flag & ~wdata[3:0];
          default:    ;
        endcase
      end
      if (rd) begin
        unique case (addr)
          REG_CTRL:   next_r.rdata = {6'h00, r.ctrl};
          REG_CMP_A:  next_r.rdata = r.buf_a;
          REG_CMP_B:  next_r.rdata = r.buf_b;
          REG_CAPTOP: next_r.rdata = r.cap_top;
          REG_COUNT:  next_r.rdata = r.count_value;
          REG_FLAGS:  next_r.rdata = {12'h000, r.flag};
          REG_ACT_A:  next_r.rdata = r.act_a;
          REG_ACT_B:  next_r.rdata = r.act_b;
          default:    next_r.rdata = 16'h0000;
        endcase
      end
      // timer clock step
      if (tick) begin
        base_a = next_r.buf_a;
        base_b = next_r.buf_b;
        if (fast_mode) begin
          wrap = at_top;
          if (at_top) begin
            next_r.count_value = BOTTOM;
            next_r.flag[FLG_OVF] = 1'b1;
            next_r.act_a = base_a;
            next_r.act_b = base_b;
          end else begin
            next_r.count_value = r.count_value + ONE;
          end
          if (at_top && top_a) next_r.flag[FLG_CMPA] = 1'b1;
          if (at_top && top_cap) next_r.flag[FLG_CAP] = 1'b1;
        end else if (pc_mode) begin
          // top and bottom last one tick each
          if (r.dir == TFP_UP) begin
            if (at_top) begin
              next_r.dir = TFP_DOWN;
              next_r.count_value = r.count_value - ONE;
              next_r.act_a = base_a;
              next_r.act_b = base_b;
              if (top_a) next_r.flag[FLG_CMPA] = 1'b1;
              if (top_cap) next_r.flag[FLG_CAP] = 1'b1;
            end else begin
              next_r.count_value = r.count_value + ONE;
            end
          end else begin
            if (at_bottom) begin
              next_r.dir = TFP_UP;
              next_r.count_value = r.count_value + ONE;
            end else begin
              next_r.count_value = r.count_value - ONE;
            end
          end
          if (at_bottom) next_r.flag[FLG_OVF] = 1'b1;
          // top counts as falling side, bottom as rising
          down_next = at_top | ((r.dir == TFP_DOWN) & ~at_bottom);
        end else begin
          next_r.count_value = r.count_value + ONE;
          if (r.count_value == MAXVAL) next_r.flag[FLG_OVF] = 1'b1;
        end
        if (match_a) next_r.flag[FLG_CMPA] = 1'b1;
        if (match_b) next_r.flag[FLG_CMPB] = 1'b1;
        next_r.wave_a = tfp_wave(r.wave_a, channel_a_output_mode,
          match_a, 1'b1, fast_mode, pc_mode, wrap, down_next, top_a);
        next_r.wave_b = tfp_wave(r.wave_b, channel_b_output_mode,
          match_b, 1'b0, fast_mode, pc_mode, wrap, down_next, top_a);
      end
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '{ctrl: CTRL_RST, buf_a: BOTTOM, buf_b: BOTTOM,
             act_a: BOTTOM, act_b: BOTTOM, cap_top: BOTTOM,
             count_value: BOTTOM, dir: TFP_UP, wave_a: 1'b0,
             wave_b: 1'b0, flag: 4'h0, rdata: 16'h0000};
    end else begin
      r <= next_r;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign rdata = r.rdata;
  assign flags = r.flag;
  // pin sees the waveform only when driven as output
  assign pin_a_oe = r.ctrl[CTRL_DIRA];
  assign pin_b_oe = r.ctrl[CTRL_DIRB];
  assign channel_a_output_pin = r.ctrl[CTRL_DIRA] & r.wave_a;
  assign channel_b_output_pin = r.ctrl[CTRL_DIRB] & r.wave_b;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  a_fast_wrap: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && fast_mode && at_top) |=>
      (r.count_value == BOTTOM && r.flag[FLG_OVF]))
    else $error("fast pwm did not wrap with overflow");
  a_pc_bottom_ovf: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && pc_mode && at_bottom) |=> r.flag[FLG_OVF])
    else $error("phase correct bottom without overflow flag");
  a_pc_top_hold: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && pc_mode && r.dir == TFP_UP && at_top) |=>
      (r.count_value == $past(r.count_value) - ONE && r.dir == TFP_DOWN))
    else $error("counter did not turn after top");
  a_match_flag_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && match_a && !(wr && addr == REG_FLAGS)) |=>
      r.flag[FLG_CMPA])
    else $error("compare a match did not set flag");
  a_buffer_hold: assert property (@(posedge clk) disable iff (reset)
    (clk_en && !tick && (fast_mode || pc_mode)) |=> $stable(r.act_a))
    else $error("active compare changed off update point");
  a_freeze_count: assert property (@(posedge clk) disable iff (reset)
    (!(clk_en && tick) && !(clk_en && wr && addr == REG_COUNT)) |=>
      $stable(r.count_value))
    else $error("counter moved without timer tick");
  a_pin_gate: assert property (@(posedge clk) disable iff (reset)
    !pin_a_oe |-> !channel_a_output_pin)
    else $error("pin a driven while direction is input");
  a_fast_clear: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && fast_mode && match_a &&
     channel_a_output_mode == COM_NONINV) |=> !r.wave_a)
    else $error("fast noninverted match did not clear");
  a_pc_up_clear: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && pc_mode && match_a && r.dir == TFP_UP && !at_top &&
     channel_a_output_mode == COM_NONINV) |=> !r.wave_a)
    else $error("phase correct up match did not clear");

  // -------------------------------------------------------------
  // further checks on turning points, flags and outputs
  // -------------------------------------------------------------
  // bottom turns the counter back up
  a_pc_turn: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && pc_mode && r.dir == TFP_DOWN && at_bottom) |=>
      (r.dir == TFP_UP && r.count_value == ONE))
    else $error("counter did not turn at bottom");
  // compare a as top raises its flag at top
  a_pc_topflag: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && pc_mode && r.dir == TFP_UP && at_top && top_a &&
     !(wr && addr == REG_FLAGS)) |=> r.flag[FLG_CMPA])
    else $error("top flag missing at top");
  // buffered compare a loads at top
  a_pc_load: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && pc_mode && r.dir == TFP_UP && at_top &&
     !(wr && addr == REG_CMP_A)) |=> r.act_a == $past(r.buf_a))
    else $error("compare a not loaded at top");
  // buffered compare b loads at wrap
  a_fast_load: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && fast_mode && at_top &&
     !(wr && addr == REG_CMP_B)) |=> r.act_b == $past(r.buf_b))
    else $error("compare b not loaded at wrap");
  // channel b match sets its flag
  a_flag_b: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && match_b && !(wr && addr == REG_FLAGS)) |=>
      r.flag[FLG_CMPB])
    else $error("compare b match did not set flag");
  // pin b hidden while direction is input
  a_pin_gate_b: assert property (@(posedge clk) disable iff (reset)
    !pin_b_oe |-> !channel_b_output_pin)
    else $error("pin b driven while direction is input");
  // wrap without match sets a noninverted output
  a_fast_set: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && fast_mode && at_top && !match_b &&
     channel_b_output_mode == COM_NONINV) |=> r.wave_b)
    else $error("fast noninverted wrap did not set");
  // falling side match sets a noninverted output
  a_pc_set: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && pc_mode && match_b && !at_bottom &&
     (r.dir == TFP_DOWN || at_top) &&
     channel_b_output_mode == COM_NONINV) |=> r.wave_b)
    else $error("phase correct down match did not set");
  // toggle on every match when compare a is top
  a_toggle_a: assert property (@(posedge clk) disable iff (reset)
    (clk_en && tick && top_a && match_a && (fast_mode || pc_mode) &&
     channel_a_output_mode == COM_TOGGLE) |=> r.wave_a != $past(r.wave_a))
    else $error("pin a did not toggle on match");
  // fixed top masks high bits of compare writes
  a_mask_b: assert property (@(posedge clk) disable iff (reset)
    (clk_en && wr && addr == REG_CMP_B && fixed_top) |=>
      (r.buf_b & ~$past(res_mask)) == BOTTOM)
    else $error("compare write not masked to resolution");
endmodule

// File: sim/tfp_load.sv
/*
  tfp_load: load on one compare output pin, with a pull-down.
  assumes: pin and enable come from the timer, clr is synchronous.
*/
`timescale 1ns/1ns
module tfp_load (
  input  wire logic        clk,
  input  wire logic        pin,
  input  wire logic        oe,
  input  wire logic        clr,
  output logic      [31:0] n_high,
  output logic      [31:0] n_rise
);
  logic level;
  logic prev;
  // pull-down holds an undriven line low
  assign level = oe ? pin : 1'b0;
  // high cycles and rising edges since the last clear
  always @(posedge clk) begin
    if (clr) begin
      n_high <= '0;
      n_rise <= '0;
    end else begin
      n_high <= n_high + 32'(level);
      n_rise <= n_rise + 32'(level & ~prev);
    end
    prev <= level;
  end
endmodule

// File: sim/timer16_fast_and_phase_pwm_tb.sv
/*
  timer16_fast_and_phase_pwm_tb: self-checking bench for tfp_pwm.
  assumes: tfp_pkg and tfp_load compiled first; one 25 MHz clock.
*/
`timescale 1ns/1ns
module timer16_fast_and_phase_pwm_tb
  import tfp_pkg::*;
;
  logic        clk, reset, clk_en, tick, wr, rd, run, clr, dirb, use_a, pc;
  logic [3:0]  addr, flags, mode;
  logic [1:0]  com;
  logic [15:0] wdata, rdata, q, last;
  logic        pa, pb, oea, oeb;
  logic [31:0] ha, hb, ra, rb;
  int          n_mismatch, n_compared, cyc, seed, n_div, div;
  int          top, cmp, nd, len;
  logic [3:0]  modes [4] = '{WGM_FA, WGM_FCAP, WGM_PCA, WGM_PCCAP};
  logic [3:0]  fixm [6] = '{WGM_PC8, WGM_PC9, WGM_PC10,
                            WGM_F8, WGM_F9, WGM_F10};
  // ---------------------------------------------------------------
  // clock, prescaler tick and hang limit
  // ---------------------------------------------------------------
  always #20 clk = ~clk;
  always @(posedge clk) begin
    div <= (div + 1 >= n_div) ? 0 : div + 1;
    tick <= run && (div == 0);
    cyc = cyc + 1;
    if (cyc == 100000) begin
      n_mismatch++;
      results();
    end
  end
  // ---------------------------------------------------------------
  // design and pin loads
  // ---------------------------------------------------------------
  tfp_pwm dut (.clk(clk), .reset(reset), .clk_en(clk_en), .tick(tick),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .channel_a_output_pin(pa), .channel_b_output_pin(pb),
    .pin_a_oe(oea), .pin_b_oe(oeb), .flags(flags));
  tfp_load load_a (.clk(clk), .pin(pa), .oe(oea), .clr(clr),
    .n_high(ha), .n_rise(ra));
  tfp_load load_b (.clk(clk), .pin(pb), .oe(oeb), .clr(clr),
    .n_high(hb), .n_rise(rb));
  // ---------------------------------------------------------------
  // bus cycles, compare and verdict
  // ---------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // high cycles of the pwm pin over two periods, in ticks
  function automatic int duty(bit p, bit inv, int t, int c);
    if (p) return inv ? 4 * (t - c) : 4 * c;
    // match wins over wrap when compare equals top
    if (c == t) return inv ? 2 * (t + 1) : 0;
    return inv ? 2 * (t - c) : 2 * (c + 1);
  endfunction
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {clk, clk_en, reset} = 3'b011;
    {tick, wr, rd, run, clr} = '0;
    {addr, wdata, cyc, div, n_mismatch, n_compared} = '0;
    n_div = 1;
    seed = 32'hcff309e1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // reset state, unmapped read
    check({flags, oea, oeb}, 0);
    rd_reg(REG_CTRL, q);
    check(q, 0);
    rd_reg(4'h8, q);
    check(q, 0);
    // fixed tops mask compare writes
    for (int k = 0; k < 6; k++) begin
      wr_reg(REG_CTRL, {12'h0, fixm[k]});
      wr_reg(REG_CMP_B, 16'hffff);
      rd_reg(REG_CMP_B, q);
      check(q, k % 3 == 0 ? TOP_8BIT : k % 3 == 1 ? TOP_9BIT : TOP_10BIT);
    end
    last = 16'h0000;
    // register tops, both polarities, extreme and random compares
    for (int i = 0; i < 24; i++) begin
      mode = modes[i % 4];
      pc = mode == WGM_PCA || mode == WGM_PCCAP;
      use_a = mode == WGM_FA || mode == WGM_PCA;
      com = (i / 4) % 2 ? COM_INV : COM_NONINV;
      top = 3 + int'($unsigned($random(seed)) % 13);
      cmp = i % 3 == 0 ? 0 : i % 3 == 1 ? top
            : 1 + int'($unsigned($random(seed)) % (top - 1));
      dirb = $random(seed);
      nd = ($random(seed) & 1) ? 8 : 1;
      run <= 1'b0;
      repeat (3) @(posedge clk);
      wr_reg(REG_CTRL, {6'h0, dirb, use_a, com,
                        use_a ? COM_TOGGLE : COM_OFF, mode});
      wr_reg(REG_CAPTOP, 16'(top));
      wr_reg(REG_CMP_A, 16'(top));
      wr_reg(REG_CMP_B, 16'(cmp));
      wr_reg(REG_COUNT, 16'h0000);
      wr_reg(REG_FLAGS, 16'h000f);
      check(flags, 0);
      rd_reg(REG_ACT_B, q);
      check(q, last);
      n_div <= nd;
      run <= 1'b1;
      len = (pc ? 4 * top : 2 * (top + 1)) * nd;
      repeat (700) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (len) @(posedge clk);
      #1;
      check(hb, dirb ? 32'(duty(pc, com[0], top, cmp) * nd) : 0);
      check(oeb, dirb);
      if (use_a) check(ha, 32'(len / 2));
      if (i % 3 == 2) check(rb, dirb ? 2 : 0);
      check(flags, {!use_a, 3'b111});
      rd_reg(REG_ACT_B, q);
      check(q, 16'(cmp));
      last = 16'(cmp);
    end
    // clock enable low freezes the counter
    run <= 1'b0;
    repeat (2) @(posedge clk);
    rd_reg(REG_COUNT, last);
    clk_en <= 1'b0;
    run <= 1'b1;
    repeat (60) @(posedge clk);
    run <= 1'b0;
    repeat (2) @(posedge clk);
    clk_en <= 1'b1;
    rd_reg(REG_COUNT, q);
    check(q, last);
    results();
  end
endmodule
